// ===== dv/event_source.sv
// Purpose: far-side model feeding event words into the buffer push port
// Assumes: push taken at a rising edge with valid and ready high
// Notes: data is inverted once released so stale words never look valid
`timescale 1ns/1ps
`default_nettype none
module event_source (
   // clock
   input wire logic mclk,
   // command
   input wire logic go,
   input wire logic [3:0] n_words,
   // push side
   input wire logic ready,
   output logic valid,
   output logic [31:0] data,
   output logic eoe
);
   initial
   begin
      valid = 1'b0;
      data = 32'h0000_0000;
      eoe = 1'b0;
   end
   // one event per go pulse, held until ready is seen at an edge
   always @(posedge mclk iff go)
   begin
      for (int i = 0; i < n_words; i++)
      begin
         #1 valid = 1'b1;
         data = 32'h0000_0100 + 32'(i);
         eoe = (i == n_words - 1); // end word closes the event
         @(posedge mclk iff ready);
      end
      #1 valid = 1'b0;
      eoe = 1'b0;
      data = ~data;
   end
endmodule : event_source
`default_nettype wire

// ===== dv/vme_readout_control_regs_tb.sv
// Purpose: self-checking bench for the readout control register bank
// Assumes: inputs change 1 ns after the rising edge of mclk
// Notes: the partner model sends one event of n_words words per go pulse
`timescale 1ns/1ps
`default_nettype none
module vme_readout_control_regs_tb;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic sel_addr_regs = 1'b0;
   logic data_reset_req = 1'b0;
   logic count_every_trigger = 1'b1;
   logic front_reset_pin = 1'b0;
   logic trig = 1'b0;
   logic trig_accepted = 1'b0;
   logic blt_start = 1'b0;
   logic blt32 = 1'b0;
   logic blt_read = 1'b0;
   logic go = 1'b0;
   logic sw_hold = 1'b0;
   logic cnt_clear = 1'b0;
   logic [3:0] n_words = 4'h0;
   localparam logic [15:0] STS_BASE = {8'h00, readout_regs_pkg::PLUGIN_CODE, 4'h0};
   logic [15:0] reg_rdata, base_high;
   logic reg_ack, in_valid, in_eoe, in_ready, blt_valid, blt_ack, berr, first, last, irq;
   logic [31:0] in_word, blt_word;
   logic [7:0] cnt_high;
   int err_count = 0;
   int n_compared = 0;
   always #50 mclk = ~mclk;
   readout_control_regs dut_u (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_ack(reg_ack), .sel_addr_regs(sel_addr_regs), .sw_reset_hold(sw_hold),
      .data_reset_req(data_reset_req), .count_every_trigger(count_every_trigger),
      .event_count_clear(cnt_clear), .front_reset_pin(front_reset_pin),
      .rotary_base(16'h3c5a), .trig(trig), .trig_accepted(trig_accepted),
      .word_in_valid(in_valid), .word_in(in_word), .word_in_eoe(in_eoe),
      .word_in_ready(in_ready), .blt_start(blt_start), .blt32(blt32), .blt_read(blt_read),
      .blt_word(blt_word), .blt_word_valid(blt_valid), .blt_ack(blt_ack),
      .bus_error_signal(berr), .chain_first(first), .chain_last(last),
      .base_addr_high(base_high), .event_irq(irq), .event_count_high_part(cnt_high));
   event_source partner_u (.mclk(mclk), .go(go), .n_words(n_words), .ready(in_ready),
      .valid(in_valid), .data(in_word), .eoe(in_eoe));
   // verdict and end of run
   task automatic print_verdict();
      if (err_count == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   task automatic tick();
      @(posedge mclk);
      #1;
   endtask : tick
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick();
      reg_wr = 1'b0;
      tick();
   endtask : wr
   // read answer stands one cycle after the strobe
   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      reg_addr = a;
      reg_rd = 1'b1;
      tick();
      reg_rd = 1'b0;
      chk({reg_ack, reg_rdata}, {1'b1, e});
      tick();
   endtask : rd
   task automatic blt(input logic [31:0] w, input logic v, input logic be);
      blt_read = 1'b1;
      tick();
      blt_read = 1'b0;
      chk({blt_ack, blt_valid, berr}, {1'b1, v, be});
      chk(blt_word, w);
      tick();
   endtask : blt
   // one event from the partner, waited for within a bound
   task automatic feed(input logic [3:0] n);
      n_words = n;
      go = 1'b1;
      tick();
      go = 1'b0;
      tick();
      for (int k = 0; k < 40 && in_valid !== 1'b0; k++)
         tick();
      chk({31'h0, in_valid}, 32'h0);
   endtask : feed
   task automatic pulse_trig(input int n, input logic acc);
      trig = 1'b1;
      trig_accepted = acc;
      repeat (n) tick();
      trig = 1'b0;
      trig_accepted = 1'b0;
      tick();
   endtask : pulse_trig
   task automatic dreset();
      data_reset_req = 1'b1;
      tick();
      data_reset_req = 1'b0;
      tick();
   endtask : dreset
   // front pin goes through a two-flop synchroniser
   task automatic pin_pulse();
      front_reset_pin = 1'b1;
      repeat (3) tick();
      front_reset_pin = 1'b0;
      repeat (4) tick();
   endtask : pin_pulse
   initial
   begin
      #1000000;
      err_count++;
      print_verdict();
   end
   // main sequence
   initial
   begin
      repeat (8) tick();
      rstn = 1'b1;
      repeat (2) tick();
      chk({31'h0, in_ready}, 32'h1);
      rd(readout_regs_pkg::OFS_MODULE_CONTROL, 16'h0000);
      rd(readout_regs_pkg::OFS_EVENT_IRQ_THRESHOLD, 16'h0000);
      rd(readout_regs_pkg::OFS_BUFFER_BOARD_STATUS, STS_BASE | 16'h0002);
      wr(readout_regs_pkg::OFS_MODULE_CONTROL, 16'hffff);
      rd(readout_regs_pkg::OFS_MODULE_CONTROL, 16'h0074);
      wr(readout_regs_pkg::OFS_BASE_ADDR_UPPER, 16'h12ab);
      wr(readout_regs_pkg::OFS_BASE_ADDR_LOWER, 16'h34cd);
      rd(readout_regs_pkg::OFS_BASE_ADDR_UPPER, 16'h00ab);
      rd(readout_regs_pkg::OFS_BASE_ADDR_LOWER, 16'h00cd);
      chk({16'h0000, base_high}, 32'h3c5a);
      sel_addr_regs = 1'b1;
      repeat (2) tick();
      chk({16'h0000, base_high}, 32'habcd);
      // every chain code, junk in the ignored bits
      for (int c = 0; c < 4; c++)
      begin
         wr(readout_regs_pkg::OFS_CHAIN_POSITION, 16'hfffc | 16'(c));
         tick();
         chk({first, last}, {30'h0, c[1], c[0]});
      end
      rd(readout_regs_pkg::OFS_CHAIN_POSITION, 16'h0000);
      pulse_trig(3, 1'b0);
      rd(readout_regs_pkg::OFS_EVENT_COUNT_LOWER, 16'h0003);
      wr(readout_regs_pkg::OFS_EVENT_COUNT_LOWER, 16'h00ff);
      dreset();
      rd(readout_regs_pkg::OFS_EVENT_COUNT_LOWER, 16'h0003);
      cnt_clear = 1'b1;
      tick();
      cnt_clear = 1'b0;
      rd(readout_regs_pkg::OFS_EVENT_COUNT_LOWER, 16'h0000);
      count_every_trigger = 1'b0;
      pulse_trig(2, 1'b0);
      pulse_trig(1, 1'b1);
      rd(readout_regs_pkg::OFS_EVENT_COUNT_LOWER, 16'h0001);
      chk({24'h0, cnt_high}, 32'h0);
      dreset();
      rd(readout_regs_pkg::OFS_EVENT_COUNT_LOWER, 16'h0000);
      count_every_trigger = 1'b1;
      // one odd event, stop at its end word, bus error and padding on
      wr(readout_regs_pkg::OFS_EVENT_IRQ_THRESHOLD, 16'h0001);
      wr(readout_regs_pkg::OFS_MODULE_CONTROL, 16'h0064);
      blt32 = 1'b1;
      feed(4'h3);
      rd(readout_regs_pkg::OFS_BUFFER_BOARD_STATUS, STS_BASE);
      chk({31'h0, irq}, 32'h1);
      blt_start = 1'b1;
      tick();
      blt_start = 1'b0;
      blt(32'h0000_0100, 1'b1, 1'b0);
      blt(32'h0000_0101, 1'b1, 1'b0);
      blt(32'h0000_0102, 1'b1, 1'b1);
      blt(readout_regs_pkg::PAD_WORD, 1'b0, 1'b1);
      blt(readout_regs_pkg::PAD_WORD, 1'b0, 1'b1);
      // single-shot, software hold and front pin resets keep the scope bit
      wr(readout_regs_pkg::OFS_MODULE_CONTROL, 16'h0074);
      wr(readout_regs_pkg::OFS_SINGLE_SHOT_RESET, 16'h5a5a);
      tick();
      rd(readout_regs_pkg::OFS_MODULE_CONTROL, 16'h0010);
      wr(readout_regs_pkg::OFS_MODULE_CONTROL, 16'h0074);
      sw_hold = 1'b1;
      tick();
      sw_hold = 1'b0;
      rd(readout_regs_pkg::OFS_MODULE_CONTROL, 16'h0010);
      wr(readout_regs_pkg::OFS_MODULE_CONTROL, 16'h0074);
      pin_pulse();
      rd(readout_regs_pkg::OFS_MODULE_CONTROL, 16'h0010);
      wr(readout_regs_pkg::OFS_MODULE_CONTROL, 16'h0024);
      pin_pulse();
      rd(readout_regs_pkg::OFS_MODULE_CONTROL, 16'h0024);
      // fill the buffer, then drain it in stop-at-empty mode
      wr(readout_regs_pkg::OFS_MODULE_CONTROL, 16'h0020);
      feed(4'hf);
      feed(4'h1);
      rd(readout_regs_pkg::OFS_BUFFER_BOARD_STATUS, STS_BASE | 16'h0004);
      chk({31'h0, in_ready}, 32'h0);
      blt_start = 1'b1;
      tick();
      blt_start = 1'b0;
      for (int k = 0; k < 15; k++)
         blt(32'h0000_0100 + 32'(k), 1'b1, 1'b0);
      blt(32'h0000_0100, 1'b1, 1'b1);
      blt(readout_regs_pkg::PAD_WORD, 1'b0, 1'b1);
      print_verdict();
   end
endmodule : vme_readout_control_regs_tb
`default_nettype wire

// ===== hw/output_buffer.sv
// Purpose: output buffer holding event words in flip-flops
// Assumes: pop_data shows the head word while pop_valid is high
// Notes: push_ready comes straight from a flip-flop; full and empty are decoded from the count register
`timescale 1ns/1ps
`default_nettype none
module output_buffer #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 16
)(
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // buffer sides
   buffer_if.store bus
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);
   localparam logic [PW:0] ONE_C = (PW+1)'(1);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [PW:0] cnt_reg, cnt_next;
   logic ready_reg, ready_next;
   logic do_push, do_pop;

   // --------------------------------
   // pointers and level
   // --------------------------------
   always_comb
   begin
      do_push = bus.push_valid && ready_reg;
      do_pop = bus.pop_ready && (cnt_reg != '0);
      wr_next = do_push ? wr_reg + PW'(1) : wr_reg;
      rd_next = do_pop ? rd_reg + PW'(1) : rd_reg;
      cnt_next = cnt_reg;
      if (do_push && !do_pop)
         cnt_next = cnt_reg + ONE_C;
      else if (do_pop && !do_push)
         cnt_next = cnt_reg - ONE_C;
      if (bus.flush)
      begin
         wr_next = '0;
         rd_next = '0;
         cnt_next = '0;
      end
      ready_next = (cnt_next != DEPTH_C);
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
         ready_reg <= 1'b0;
      end
      else
      begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
         ready_reg <= ready_next;
      end
   end

   // storage, written only on an accepted push
   always_ff @(posedge mclk)
   begin
      if (do_push && !bus.flush)
         mem_reg[wr_reg] <= bus.push_data;
   end

   assign bus.push_ready = ready_reg;
   assign bus.pop_valid = (cnt_reg != '0);
   assign bus.pop_data = mem_reg[rd_reg];
   assign bus.full = (cnt_reg == DEPTH_C);
   assign bus.empty = (cnt_reg == '0);
   assign bus.last = (cnt_reg == ONE_C);
endmodule : output_buffer
`default_nettype wire

// ===== hw/readout_control_regs.sv
// Purpose: control, address decoder, chain, threshold, status and event counter registers
// Assumes: register strobes and readout requests are one-cycle pulses on mclk
// Notes: rstn is the hardware reset; software and data resets are derived here
//
// Contract
// - stop-at-empty mode: all words returned, then not-valid words once buffer empty
// - stop-at-first-event mode: words up to first end-of-event word, then not-valid
// - front reset: data reset when scope bit 0, software reset when 1
// - software and hardware reset clear control; scope bit cleared by hardware only
// - align enabled in 32-bit block readout pads odd events with one not-valid word
// - control bits 7 to 15 hold nothing and read zero
// - upper decoder register holds base address bits 31..24
// - lower decoder register holds base address bits 23..16
// - any write to single-shot location resets the module
// - first and last flags give board position in chain
// - only chain bits 0 and 1 used; location is write only
// - interrupt request when stored events equal nonzero 5-bit threshold
// - status flag high when output buffer empty
// - status flag high when output buffer full
// - four status bits report fixed plug-in board code
// - low counter register returns counter bits 15..0
// - counting mode selects every trigger or accepted triggers only
// - counter cleared by counter reset, software, hardware, and data reset if accepted-only
// - high counter part returns counter bits 23..16
// - accepted-only mode counts accepted triggers; default counts every trigger
`timescale 1ns/1ps
`default_nettype none
module readout_control_regs (
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // register port
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_ack,
   // settings held in other registers of the module
   input wire logic sel_addr_regs,
   input wire logic sw_reset_hold,
   input wire logic data_reset_req,
   input wire logic count_every_trigger,
   input wire logic event_count_clear,
   // pins
   input wire logic front_reset_pin,
   input wire logic [15:0] rotary_base,
   // triggers
   input wire logic trig,
   input wire logic trig_accepted,
   // event words into the buffer
   input wire logic word_in_valid,
   input wire logic [31:0] word_in,
   input wire logic word_in_eoe,
   output logic word_in_ready,
   // block readout
   input wire logic blt_start,
   input wire logic blt32,
   input wire logic blt_read,
   output logic [31:0] blt_word,
   output logic blt_word_valid,
   output logic blt_ack,
   output logic bus_error_signal,
   // chain, base, interrupt and counter high part
   output logic chain_first,
   output logic chain_last,
   output logic [15:0] base_addr_high,
   output logic event_irq,
   output logic [7:0] event_count_high_part
);
   localparam int FW = readout_regs_pkg::WORD_W + 1;

   buffer_if #(.WIDTH(FW)) buf_bus ();

   output_buffer #(.WIDTH(FW), .DEPTH(readout_regs_pkg::FIFO_DEPTH)) u_buf (
      .mclk(mclk),
      .rstn(rstn),
      .bus(buf_bus)
   );

   function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // --------------------------------
   // pin synchronisers
   // --------------------------------
   logic front_s1_reg, front_s2_reg;
   logic [15:0] rot_s1_reg, rot_s2_reg;

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         front_s1_reg <= 1'b0;
         front_s2_reg <= 1'b0;
         rot_s1_reg <= readout_regs_pkg::REG_ZERO;
         rot_s2_reg <= readout_regs_pkg::REG_ZERO;
      end
      else
      begin
         front_s1_reg <= front_reset_pin;
         front_s2_reg <= front_s1_reg;
         rot_s1_reg <= rotary_base;
         rot_s2_reg <= rot_s1_reg;
      end
   end

   // --------------------------------
   // register file
   // --------------------------------
   logic stop_first_reg, stop_first_next, scope_reg, scope_next;
   logic berr_en_reg, berr_en_next, align_reg, align_next;
   logic [7:0] upper_reg, upper_next, lower_reg, lower_next;
   logic first_reg, first_next, last_reg, last_next;
   logic [4:0] thresh_reg, thresh_next;
   logic [23:0] evcnt_reg, evcnt_next;
   logic [4:0] events_reg, events_next;
   logic [15:0] rdata_reg, rdata_next, base_reg, base_next;
   logic ack_reg, irq_reg, irq_next;
   logic [7:0] cnt_hi_reg;
   logic soft_rst, data_rst, cnt_inc, push_eoe, pop_eoe, popping;

   always_comb
   begin
      soft_rst = sw_reset_hold || (front_s2_reg && scope_reg)
                 || (reg_wr && hit(reg_addr, readout_regs_pkg::OFS_SINGLE_SHOT_RESET));
      data_rst = data_reset_req || (front_s2_reg && !scope_reg);
      stop_first_next = stop_first_reg;
      scope_next = scope_reg;
      berr_en_next = berr_en_reg;
      align_next = align_reg;
      upper_next = upper_reg;
      lower_next = lower_reg;
      first_next = first_reg;
      last_next = last_reg;
      thresh_next = thresh_reg;
      if (reg_wr && hit(reg_addr, readout_regs_pkg::OFS_MODULE_CONTROL))
      begin
         // bits 7..15 are not stored
         stop_first_next = reg_wdata[readout_regs_pkg::CTL_STOP_FIRST_BIT];
         scope_next = reg_wdata[readout_regs_pkg::CTL_SCOPE_BIT];
         berr_en_next = reg_wdata[readout_regs_pkg::CTL_BERR_EN_BIT];
         align_next = reg_wdata[readout_regs_pkg::CTL_ALIGN_BIT];
      end
      if (reg_wr && hit(reg_addr, readout_regs_pkg::OFS_BASE_ADDR_UPPER))
         upper_next = reg_wdata[7:0];
      if (reg_wr && hit(reg_addr, readout_regs_pkg::OFS_BASE_ADDR_LOWER))
         lower_next = reg_wdata[7:0];
      if (reg_wr && hit(reg_addr, readout_regs_pkg::OFS_CHAIN_POSITION))
      begin
         first_next = reg_wdata[readout_regs_pkg::CHAIN_FIRST_BIT];
         last_next = reg_wdata[readout_regs_pkg::CHAIN_LAST_BIT];
      end
      if (reg_wr && hit(reg_addr, readout_regs_pkg::OFS_EVENT_IRQ_THRESHOLD))
         thresh_next = reg_wdata[4:0];
      if (soft_rst)
      begin
         // scope bit survives a software reset
         stop_first_next = 1'b0;
         berr_en_next = 1'b0;
         align_next = 1'b0;
      end
      // event counter
      cnt_inc = count_every_trigger ? trig : trig_accepted;
      evcnt_next = cnt_inc ? evcnt_reg + 24'h000001 : evcnt_reg;
      if (event_count_clear || soft_rst || (data_rst && !count_every_trigger))
         evcnt_next = 24'h000000;
      // stored events and interrupt
      push_eoe = buf_bus.push_valid && buf_bus.push_ready && word_in_eoe;
      pop_eoe = popping && buf_bus.pop_data[readout_regs_pkg::WORD_W];
      events_next = events_reg + 5'(push_eoe) - 5'(pop_eoe);
      if (soft_rst || data_rst)
         events_next = 5'h00;
      irq_next = (thresh_reg != 5'h00) && (events_reg == thresh_reg);
      base_next = sel_addr_regs ? {upper_reg, lower_reg} : rot_s2_reg;
      // read answer
      rdata_next = readout_regs_pkg::REG_ZERO;
      if (hit(reg_addr, readout_regs_pkg::OFS_MODULE_CONTROL))
      begin
         rdata_next[readout_regs_pkg::CTL_STOP_FIRST_BIT] = stop_first_reg;
         rdata_next[readout_regs_pkg::CTL_SCOPE_BIT] = scope_reg;
         rdata_next[readout_regs_pkg::CTL_BERR_EN_BIT] = berr_en_reg;
         rdata_next[readout_regs_pkg::CTL_ALIGN_BIT] = align_reg;
      end
      else if (hit(reg_addr, readout_regs_pkg::OFS_BASE_ADDR_UPPER))
         rdata_next[7:0] = upper_reg;
      else if (hit(reg_addr, readout_regs_pkg::OFS_BASE_ADDR_LOWER))
         rdata_next[7:0] = lower_reg;
      else if (hit(reg_addr, readout_regs_pkg::OFS_EVENT_IRQ_THRESHOLD))
         rdata_next[4:0] = thresh_reg;
      else if (hit(reg_addr, readout_regs_pkg::OFS_BUFFER_BOARD_STATUS))
      begin
         rdata_next[readout_regs_pkg::STS_EMPTY_BIT] = buf_bus.empty;
         rdata_next[readout_regs_pkg::STS_FULL_BIT] = buf_bus.full;
         rdata_next[readout_regs_pkg::STS_PLUGIN_LSB +: 4] =
            readout_regs_pkg::PLUGIN_CODE;
      end
      else if (hit(reg_addr, readout_regs_pkg::OFS_EVENT_COUNT_LOWER))
         rdata_next = evcnt_reg[15:0];
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         stop_first_reg <= 1'b0;
         scope_reg <= 1'b0;
         berr_en_reg <= 1'b0;
         align_reg <= 1'b0;
         upper_reg <= 8'h00;
         lower_reg <= 8'h00;
         first_reg <= 1'b0;
         last_reg <= 1'b0;
         thresh_reg <= 5'h00;
         evcnt_reg <= 24'h000000;
         events_reg <= 5'h00;
         rdata_reg <= readout_regs_pkg::REG_ZERO;
         ack_reg <= 1'b0;
         irq_reg <= 1'b0;
         base_reg <= readout_regs_pkg::REG_ZERO;
         cnt_hi_reg <= 8'h00;
      end
      else
      begin
         stop_first_reg <= stop_first_next;
         scope_reg <= scope_next;
         berr_en_reg <= berr_en_next;
         align_reg <= align_next;
         upper_reg <= upper_next;
         lower_reg <= lower_next;
         first_reg <= first_next;
         last_reg <= last_next;
         thresh_reg <= thresh_next;
         evcnt_reg <= evcnt_next;
         events_reg <= events_next;
         rdata_reg <= rdata_next;
         ack_reg <= reg_rd;
         irq_reg <= irq_next;
         base_reg <= base_next;
         cnt_hi_reg <= evcnt_next[23:16];
      end
   end

   // --------------------------------
   // block readout
   // --------------------------------
   logic done_reg, done_next, odd_reg, odd_next, pad_reg, pad_next;
   logic [31:0] word_reg, word_next;
   logic valid_reg, valid_next, bok_reg, berr_reg, berr_next;

   always_comb
   begin
      popping = 1'b0;
      done_next = blt_start ? 1'b0 : done_reg;
      odd_next = odd_reg;
      pad_next = pad_reg;
      word_next = readout_regs_pkg::PAD_WORD;
      valid_next = 1'b0;
      berr_next = blt_start ? 1'b0 : berr_reg;
      if (blt_read)
      begin
         if (pad_reg)
            pad_next = 1'b0;
         else if (!done_reg && buf_bus.pop_valid)
         begin
            popping = 1'b1;
            valid_next = 1'b1;
            word_next = buf_bus.pop_data[31:0];
            if (buf_bus.pop_data[readout_regs_pkg::WORD_W])
            begin
               odd_next = 1'b0;
               pad_next = align_reg && blt32 && !odd_reg;
               done_next = stop_first_reg;
               berr_next = berr_en_reg && stop_first_reg;
            end
            else
               odd_next = !odd_reg;
            if (!stop_first_reg && buf_bus.last)
               berr_next = berr_en_reg;
         end
      end
      if (soft_rst || data_rst)
      begin
         done_next = 1'b0;
         odd_next = 1'b0;
         pad_next = 1'b0;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         done_reg <= 1'b0;
         odd_reg <= 1'b0;
         pad_reg <= 1'b0;
         word_reg <= 32'h0000_0000;
         valid_reg <= 1'b0;
         bok_reg <= 1'b0;
         berr_reg <= 1'b0;
      end
      else
      begin
         done_reg <= done_next;
         odd_reg <= odd_next;
         pad_reg <= pad_next;
         word_reg <= word_next;
         valid_reg <= valid_next;
         bok_reg <= blt_read;
         berr_reg <= berr_next;
      end
   end

   assign buf_bus.push_valid = word_in_valid;
   assign buf_bus.push_data = {word_in_eoe, word_in};
   assign buf_bus.pop_ready = popping;
   assign buf_bus.flush = soft_rst || data_rst;
   assign word_in_ready = buf_bus.push_ready;
   assign reg_rdata = rdata_reg;
   assign reg_ack = ack_reg;
   assign blt_word = word_reg;
   assign blt_word_valid = valid_reg;
   assign blt_ack = bok_reg;
   assign bus_error_signal = berr_reg;
   assign chain_first = first_reg;
   assign chain_last = last_reg;
   assign base_addr_high = base_reg;
   assign event_irq = irq_reg;
   assign event_count_high_part = cnt_hi_reg;

   // --------------------------------
   // checks
   // --------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   stop_empty_a: assert property (blt_read && !pad_reg && !buf_bus.pop_valid |=>
      blt_ack && !blt_word_valid) else $error("word valid from empty buffer");
   stop_first_a: assert property (done_reg && !blt_start && blt_read && !pad_reg &&
      !soft_rst && !data_rst |=> !blt_word_valid) else $error("word valid after end of event");
   berr_eoe_a: assert property (pop_eoe && stop_first_reg && berr_en_reg |=>
      bus_error_signal) else $error("no bus error on end word");
   scope_keep_a: assert property (soft_rst && !(reg_wr && hit(reg_addr,
      readout_regs_pkg::OFS_MODULE_CONTROL)) |=> scope_reg == $past(scope_reg) &&
      !stop_first_reg && !berr_en_reg) else $error("control reset wrong");
   front_data_a: assert property (front_s2_reg && !scope_reg |=>
      buf_bus.empty) else $error("front reset kept data");
   pad_word_a: assert property (pad_reg && blt_read |=>
      blt_ack && !blt_word_valid && !pad_reg) else $error("pad word wrong");
   irq_match_a: assert property ((thresh_reg != 5'h00) && (events_reg == thresh_reg) |=>
      event_irq) else $error("missed interrupt");
   irq_off_a: assert property (thresh_reg == 5'h00 |=>
      !event_irq) else $error("interrupt while disabled");
   cnt_wrap_a: assert property (cnt_inc && !event_count_clear && !soft_rst &&
      !data_rst |=> evcnt_reg == $past(evcnt_reg) + 24'h000001) else $error("counter step wrong");
   base_sel_a: assert property (sel_addr_regs |=>
      base_addr_high == $past({upper_reg, lower_reg})) else $error("base not relocated");

   pad_seen_c: cover property (pad_reg && blt_read);
   berr_seen_c: cover property (bus_error_signal);
   irq_seen_c: cover property (event_irq);
   full_seen_c: cover property (buf_bus.full);
endmodule : readout_control_regs
`default_nettype wire

// ===== inc/buffer_if.sv
// Purpose: push and pop sides of the output buffer
// Assumes: one clock, valid and ready handshakes on both sides
// Notes: flush empties the buffer in one cycle
`timescale 1ns/1ps
`default_nettype none
interface buffer_if #(parameter int WIDTH = 33);
   logic push_valid;
   logic push_ready;
   logic [WIDTH-1:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [WIDTH-1:0] pop_data;
   logic flush;
   logic full;
   logic empty;
   logic last;
   // buffer end
   modport store (input push_valid, push_data, pop_ready, flush,
                  output push_ready, pop_valid, pop_data, full, empty, last);
   // controller end
   modport user (output push_valid, push_data, pop_ready, flush,
                 input push_ready, pop_valid, pop_data, full, empty, last);
endinterface : buffer_if
`default_nettype wire

// ===== inc/readout_regs_pkg.sv
// Purpose: constants shared by the readout control register bank and its output buffer
// Assumes: 16-bit register data, word offsets as seen on the module address port
// Notes: plugin code value is arbitrary and stands for a fixed strapped board type
package readout_regs_pkg;
   // register offsets
   localparam logic [15:0] OFS_MODULE_CONTROL = 16'h1010;
   localparam logic [15:0] OFS_BASE_ADDR_UPPER = 16'h1012;
   localparam logic [15:0] OFS_BASE_ADDR_LOWER = 16'h1014;
   localparam logic [15:0] OFS_SINGLE_SHOT_RESET = 16'h1016;
   localparam logic [15:0] OFS_CHAIN_POSITION = 16'h101a;
   localparam logic [15:0] OFS_EVENT_IRQ_THRESHOLD = 16'h1020;
   localparam logic [15:0] OFS_BUFFER_BOARD_STATUS = 16'h1022;
   localparam logic [15:0] OFS_EVENT_COUNT_LOWER = 16'h1024;
   // module_control bit positions
   localparam int CTL_STOP_FIRST_BIT = 2;
   localparam int CTL_SCOPE_BIT = 4;
   localparam int CTL_BERR_EN_BIT = 5;
   localparam int CTL_ALIGN_BIT = 6;
   // chain_position_control bits
   localparam int CHAIN_LAST_BIT = 0;
   localparam int CHAIN_FIRST_BIT = 1;
   // buffer_and_board_status bits
   localparam int STS_EMPTY_BIT = 1;
   localparam int STS_FULL_BIT = 2;
   localparam int STS_PLUGIN_LSB = 4;
   localparam logic [3:0] PLUGIN_CODE = 4'h5; // arbitrary value
   // widths and reset values
   localparam int REG_W = 16;
   localparam int ADDR_FIELD_W = 8;
   localparam int THRESH_W = 5;
   localparam int EVCNT_W = 24;
   localparam int EVCNT_LOW_W = 16;
   localparam int WORD_W = 32;
   localparam int FIFO_DEPTH = 16;
   localparam logic [15:0] REG_ZERO = 16'h0000;
   localparam logic [31:0] PAD_WORD = 32'h0600_0000;
endpackage : readout_regs_pkg
